// File: core/twrs_buf.sv
// two-entry write buffer between bus engine and register file
module twrs_buf (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [15:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [15:0] out_data
);
  logic [15:0] mem [0:1];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // full and empty flags from occupancy
  assign in_ready = (count != 2'(twrs_pkg::BUF_DEPTH));
  assign out_valid = (count != 2'd0);
  assign out_data = mem[rd_ptr];

  // pointer and occupancy update
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'd0;
    end else if (clk_en) begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : twrs_buf

// File: core/twrs_slave.sv
// How it works
// - bytes are eight bits, msb first
// - sample data on clock rise, change when low
// - data fall/rise with clock high: start/stop
// - ack own address by pulling data low
// - write: address, index, data, each acked
// - master ack advances pointer, sends next
// - unimplemented index reads as zero
// - page mode: consecutive indices, auto increment
// - repeat mode: index/data pairs
// - lock refuses writes above 0x7f
// - write 0xb4, read 0xb5 by default
// - no clock stretching, data ready immediately
// - index zero selects page, lsb ignored
module twrs_slave (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic port_enable,
  input wire logic write_mode,
  input wire logic high_lock,
  input wire logic [7:0] slave_address_config,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic scl_out,
  output logic scl_oe,
  output logic [7:0] page_select,
  output logic busy
);
  // registers of two pages
  logic [7:0] regs [0:1][0:twrs_pkg::REG_COUNT-1];
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_q;
  logic sda_q;
  twrs_pkg::twrs_state_type state;
  twrs_pkg::twrs_state_type after_ack;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] pointer;
  logic [7:0] tx_byte;
  logic ack_drive;
  logic [7:0] page_reg;
  logic buf_in_valid;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [15:0] buf_out_data;
  logic [15:0] buf_in_data;

  // double-flop synchronisers on both pins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scl_sync <= 2'b11;
      sda_sync <= 2'b11;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (clk_en) begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_q <= scl_sync[1];
      sda_q <= sda_sync[1];
    end
  end

  // edge and condition decode
  wire scl_rise = scl_sync[1] && !scl_q;
  wire scl_fall = !scl_sync[1] && scl_q;
  wire start_det = scl_sync[1] && scl_q && sda_q && !sda_sync[1];
  wire stop_det = scl_sync[1] && scl_q && !sda_q && sda_sync[1];
  wire [7:0] rd_addr = slave_address_config | 8'h01;
  wire addr_hit_wr = shreg == slave_address_config;
  wire addr_hit_rd = shreg == rd_addr;
  wire byte_done = scl_rise && bit_cnt == twrs_pkg::LAST_BIT;
  wire [7:0] rx_byte = {shreg[6:0], sda_sync[1]};
  wire ptr_valid = pointer < 8'(twrs_pkg::REG_COUNT);
  wire page_bit = page_reg[1];
  // index zero reads back the page register itself
  wire page_hit = pointer == twrs_pkg::PAGE_REG_INDEX;
  wire [7:0] reg_value = page_hit ? page_reg : regs[page_bit][pointer[5:0]];
  wire [7:0] read_value = ptr_valid ? reg_value : 8'h00;
  wire locked = high_lock && (pointer > twrs_pkg::LOCK_LIMIT);

  assign scl_out = 1'b0;
  assign scl_oe = 1'b0;
  assign page_select = page_reg;
  assign busy = state != twrs_pkg::ST_IDLE;
  assign buf_in_data = {pointer, rx_byte};
  assign buf_in_valid = clk_en && state == twrs_pkg::ST_WDATA && byte_done && !locked;

  // write buffer holds each word one cycle; the register file always takes it (out_ready tied high)
  twrs_buf u_buf (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(buf_in_data),
    .out_valid(buf_out_valid),
    .out_ready(1'b1),
    .out_data(buf_out_data)
  );

  // register file and page register drain the buffer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      page_reg <= twrs_pkg::PAGE_RESET;
      // every implemented register starts from its reset value
      for (int p = 0; p < 2; p++) begin
        for (int i = 0; i < twrs_pkg::REG_COUNT; i++) begin
          regs[p][i] <= twrs_pkg::REG_RESET;
        end
      end
    end else if (clk_en && buf_out_valid) begin
      if (buf_out_data[15:8] == twrs_pkg::PAGE_REG_INDEX) begin
        page_reg <= buf_out_data[7:0];
      end else if (buf_out_data[15:8] < 8'(twrs_pkg::REG_COUNT)) begin
        regs[page_bit][buf_out_data[13:8]] <= buf_out_data[7:0];
      end
    end
  end

  // bus engine
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= twrs_pkg::ST_IDLE;
      after_ack <= twrs_pkg::ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      pointer <= 8'h00;
      tx_byte <= 8'h00;
      ack_drive <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else if (clk_en) begin
      if (!port_enable || stop_det) begin
        state <= twrs_pkg::ST_IDLE;
        sda_oe <= 1'b0;
      end else if (start_det) begin
        state <= twrs_pkg::ST_ADDR;
        bit_cnt <= 4'h0;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          twrs_pkg::ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          twrs_pkg::ST_ADDR, twrs_pkg::ST_INDEX, twrs_pkg::ST_WDATA: begin
            if (scl_rise) begin
              shreg <= rx_byte;
              bit_cnt <= bit_cnt + 4'h1;
            end
            if (scl_fall && bit_cnt == twrs_pkg::ACK_SLOT) begin
              bit_cnt <= 4'h0;
              if (state == twrs_pkg::ST_ADDR && (addr_hit_wr || addr_hit_rd)) begin
                sda_oe <= 1'b1;
                after_ack <= addr_hit_rd ? twrs_pkg::ST_RDATA : twrs_pkg::ST_INDEX;
                tx_byte <= read_value;
                state <= twrs_pkg::ST_ACK;
              end else if (state == twrs_pkg::ST_INDEX) begin
                pointer <= shreg;
                sda_oe <= 1'b1;
                after_ack <= twrs_pkg::ST_WDATA;
                state <= twrs_pkg::ST_ACK;
              end else if (state == twrs_pkg::ST_WDATA) begin
                sda_oe <= 1'b1;
                if (write_mode == twrs_pkg::WMODE_REPEAT) begin
                  after_ack <= twrs_pkg::ST_INDEX;
                end else begin
                  after_ack <= twrs_pkg::ST_WDATA;
                  pointer <= pointer + 8'h01;
                end
                state <= twrs_pkg::ST_ACK;
              end else begin
                state <= twrs_pkg::ST_IDLE;
              end
            end
          end
          twrs_pkg::ST_ACK: begin
            if (scl_fall) begin
              state <= after_ack;
              if (after_ack == twrs_pkg::ST_RDATA) begin
                sda_oe <= !tx_byte[7];
                tx_byte <= {tx_byte[6:0], 1'b0};
                bit_cnt <= 4'h1;
              end else begin
                sda_oe <= 1'b0;
              end
            end
          end
          twrs_pkg::ST_RDATA: begin
            if (scl_fall) begin
              if (bit_cnt == twrs_pkg::ACK_SLOT) begin
                sda_oe <= 1'b0;
                state <= twrs_pkg::ST_RACK;
              end else begin
                sda_oe <= !tx_byte[7];
                tx_byte <= {tx_byte[6:0], 1'b0};
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          twrs_pkg::ST_RACK: begin
            if (scl_rise) begin
              if (!sda_sync[1]) begin
                pointer <= pointer + 8'h01;
                after_ack <= twrs_pkg::ST_RDATA;
                state <= twrs_pkg::ST_ACK;
              end else begin
                state <= twrs_pkg::ST_IDLE;
              end
            end
          end
          default: begin
            state <= twrs_pkg::ST_IDLE;
          end
        endcase
        if (state == twrs_pkg::ST_RACK && scl_rise && !sda_sync[1]) begin
          tx_byte <= (pointer + 8'h01 < 8'(twrs_pkg::REG_COUNT)) ?
            regs[page_bit][6'(pointer + 8'h01)] : 8'h00;
        end
      end
    end
  end

  // the data line is pulled low only while acking or sending zero
  a_ack_low: assert property (@(posedge sys_clk) disable iff (rst)
    sda_oe |-> !sda_out) else $error("data driven high");
  a_no_stretch: assert property (@(posedge sys_clk) disable iff (rst)
    !scl_oe) else $error("clock stretched");
  a_stop_idle: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && stop_det |=> state == twrs_pkg::ST_IDLE) else $error("stop ignored");
  a_start_addr: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && port_enable && start_det && !stop_det |=> state == twrs_pkg::ST_ADDR)
    else $error("start ignored");
  a_lock_block: assert property (@(posedge sys_clk) disable iff (rst)
    buf_in_valid |-> !(high_lock && pointer > twrs_pkg::LOCK_LIMIT))
    else $error("locked write passed");
  a_page_inc: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && state == twrs_pkg::ST_WDATA && scl_fall && bit_cnt == twrs_pkg::ACK_SLOT
    && write_mode == twrs_pkg::WMODE_PAGE && !stop_det && !start_det && port_enable
    |=> pointer == $past(pointer) + 8'h01) else $error("no increment");
  a_repeat_idx: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && state == twrs_pkg::ST_WDATA && scl_fall && bit_cnt == twrs_pkg::ACK_SLOT
    && write_mode == twrs_pkg::WMODE_REPEAT && !stop_det && !start_det && port_enable
    |=> after_ack == twrs_pkg::ST_INDEX) else $error("pair mode wrong");
  a_read_adv: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && port_enable && state == twrs_pkg::ST_RACK && scl_rise && !sda_sync[1]
    && !start_det && !stop_det |=> pointer == $past(pointer) + 8'h01)
    else $error("read pointer stuck");
  // while the port is enabled, our data drive only moves while the bus clock is low
  a_data_clk_low: assert property (@(posedge sys_clk) disable iff (rst)
    $changed(sda_oe) && $past(port_enable) |-> !scl_sync[1])
    else $error("data drive moved with clock high");
  // a received word always finds room in the write buffer
  a_buf_room: assert property (@(posedge sys_clk) disable iff (rst)
    buf_in_valid |-> buf_in_ready) else $error("write word lost");
endmodule : twrs_slave

// File: shared/twrs_pkg.sv
package twrs_pkg;
  // slave address defaults (8-bit form, write and read)
  localparam logic [7:0] WR_ADDR_DEFAULT = 8'hb4;
  localparam logic [7:0] RD_ADDR_DEFAULT = 8'hb5;
  // write-protect boundary: indices above this are locked
  localparam logic [7:0] LOCK_LIMIT = 8'h7f;
  // page-select register index and bits per byte
  localparam logic [7:0] PAGE_REG_INDEX = 8'h00;
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  // implemented registers per page, reset values
  localparam int REG_COUNT = 64;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  // write-sequence select encodings
  localparam logic WMODE_PAGE = 1'b0;
  localparam logic WMODE_REPEAT = 1'b1;
  // buffer depth of the write path
  localparam int BUF_DEPTH = 2;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_INDEX, ST_WDATA, ST_RDATA, ST_ACK, ST_RACK
  } twrs_state_type;
endpackage : twrs_pkg

// File: testbench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] WA = twrs_pkg::WR_ADDR_DEFAULT;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic port_enable = 1'b1;
  logic write_mode = twrs_pkg::WMODE_PAGE;
  logic high_lock = 1'b0;
  logic sda_out, sda_oe, scl_out, scl_oe, busy, m_sda, m_scl;
  logic stretched = 1'b0;
  logic [7:0] page_select;
  int err_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  // wired-and bus with pull-ups
  wire logic sda_bus = !(m_sda || (sda_oe && !sda_out));
  wire logic scl_bus = !(m_scl || (scl_oe && !scl_out));
  always #20 sys_clk = ~sys_clk;
  twrs_slave twrs_slave_i (.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1),
    .port_enable(port_enable), .write_mode(write_mode), .high_lock(high_lock),
    .slave_address_config(WA), .scl_in(scl_bus), .sda_in(sda_bus),
    .sda_out(sda_out), .sda_oe(sda_oe), .scl_out(scl_out), .scl_oe(scl_oe),
    .page_select(page_select), .busy(busy));
  twrs_host_model twrs_host_model_i (.sda_bus(sda_bus), .sda_low(m_sda), .scl_low(m_scl));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    if (err_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  // hang guard and stretch watch
  always @(posedge sys_clk) begin
    cycles++;
    if (scl_oe !== 1'b0) stretched = 1'b1;
    if (cycles == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  // start, address, payload bytes each acked (sent only when an address ack is expected), stop
  task automatic wr(input logic [7:0] addr, input logic [7:0] b[$], input logic ea);
    logic a;
    twrs_host_model_i.start();
    twrs_host_model_i.send(addr, a);
    check({7'h00, a}, {7'h00, ea});
    if (ea) foreach (b[i]) begin
      twrs_host_model_i.send(b[i], a);
      check({7'h00, a}, 8'h01);
    end
    twrs_host_model_i.stop();
  endtask : wr
  // index write, restart, two bytes: first acked, second nacked
  task automatic rd(input logic [7:0] idx, input logic [7:0] e0, input logic [7:0] e1);
    logic a;
    logic [7:0] d;
    twrs_host_model_i.start();
    twrs_host_model_i.send(WA, a);
    twrs_host_model_i.send(idx, a);
    check({7'h00, a}, 8'h01);
    twrs_host_model_i.start();
    twrs_host_model_i.send(twrs_pkg::RD_ADDR_DEFAULT, a);
    check({7'h00, a}, 8'h01);
    twrs_host_model_i.recv(1'b1, d);
    check(d, e0);
    twrs_host_model_i.recv(1'b0, d);
    check(d, e1);
    twrs_host_model_i.stop();
  endtask : rd
  task automatic t_page_write();
    wr(WA, '{8'h01, 8'haa, 8'h55}, 1'b1);
    rd(8'h01, 8'haa, 8'h55);
  endtask : t_page_write
  task automatic t_repeat_write();
    @(posedge sys_clk) #2 write_mode = twrs_pkg::WMODE_REPEAT;
    wr(WA, '{8'h05, 8'h11, 8'h09, 8'h22}, 1'b1);
    rd(8'h05, 8'h11, twrs_pkg::REG_RESET);
    rd(8'h09, 8'h22, twrs_pkg::REG_RESET);
    @(posedge sys_clk) #2 write_mode = twrs_pkg::WMODE_PAGE;
  endtask : t_repeat_write
  task automatic t_unimpl();
    wr(WA, '{8'h3f, 8'h3c}, 1'b1);
    rd(8'h3f, 8'h3c, 8'h00);
    rd(8'h50, 8'h00, 8'h00);
  endtask : t_unimpl
  task automatic t_lock();
    @(posedge sys_clk) #2 high_lock = 1'b1;
    wr(WA, '{8'h80, 8'hff}, 1'b1);
    wr(WA, '{8'h02, 8'h66}, 1'b1);
    rd(8'h80, 8'h00, 8'h00);
    rd(8'h02, 8'h66, twrs_pkg::REG_RESET);
    @(posedge sys_clk) #2 high_lock = 1'b0;
  endtask : t_lock
  task automatic t_foreign();
    wr(8'hb0, '{8'h00}, 1'b0);
    @(posedge sys_clk) #2 port_enable = 1'b0;
    wr(WA, '{8'h00}, 1'b0);
    @(posedge sys_clk) #2 port_enable = 1'b1;
    check({7'h00, busy}, 8'h00);
  endtask : t_foreign
  task automatic t_page_select();
    wr(WA, '{8'h00, 8'h02}, 1'b1);
    check(page_select, 8'h02);
    wr(WA, '{8'h01, 8'h77}, 1'b1);
    rd(8'h01, 8'h77, twrs_pkg::REG_RESET);
    rd(8'h00, 8'h02, 8'h77);
    wr(WA, '{8'h00, 8'h01}, 1'b1);
    check(page_select, 8'h01);
    rd(8'h01, 8'haa, 8'h66);
  endtask : t_page_select
  initial begin
    repeat (4) @(posedge sys_clk);
    #2 rst = 1'b0;
    repeat (4) @(posedge sys_clk);
    // keep every bus edge off the sampling edge
    #2;
    t_page_write();
    t_repeat_write();
    t_unimpl();
    t_lock();
    t_foreign();
    t_page_select();
    check({7'h00, stretched}, 8'h00);
    report_and_stop();
  end
endmodule : tb_top

// File: testbench/twrs_host_model.sv
// bus master model: pulls lines low, released lines float high
module twrs_host_model (
  input wire logic sda_bus,
  output logic sda_low,
  output logic scl_low
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam time Q = 80;
  // bus starts idle
  initial begin
    sda_low = 1'b0;
    scl_low = 1'b0;
  end
  // one clock: data set while clock low, sampled while high
  task automatic put_bit(input logic b, output logic r);
    sda_low = !b;
    #Q;
    scl_low = 1'b0;
    #Q;
    r = sda_bus;
    #Q;
    scl_low = 1'b1;
    #Q;
  endtask : put_bit
  // start or restart, long low wait lets an ack release first
  task automatic start();
    sda_low = 1'b0;
    #(2*Q);
    scl_low = 1'b0;
    #(2*Q);
    sda_low = 1'b1;
    #(2*Q);
    scl_low = 1'b1;
    #Q;
  endtask : start
  // data rises while clock high
  task automatic stop();
    sda_low = 1'b1;
    #Q;
    scl_low = 1'b0;
    #(2*Q);
    sda_low = 1'b0;
    #(2*Q);
  endtask : stop
  // byte out msb first, ack returned
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], r);
    end
    put_bit(1'b1, r);
    ack = !r;
  endtask : send
  // byte in msb first, then ack or nack
  task automatic recv(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, r);
      d[i] = r;
    end
    put_bit(!more, r);
  endtask : recv
endmodule : twrs_host_model
